// >>> dv/i2ce_master_bfm.sv
// Bus controller model: makes the bus clock and drives transfers
`timescale 1ns/100ps
`default_nettype none
module i2ce_master_bfm (
    input  wire logic sda,
    output var  logic scl,
    output var  logic pull
);
    // ----------------------------------------------------------------
    // Bit and frame tasks, 800 ns bus clock, idle with clock high
    // ----------------------------------------------------------------
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Data moves only mid low phase, clear of both clock edges
    task automatic bit_out(input logic b);
        #200 pull = !b;
        #200 scl = 1'b1;
        #400 scl = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        #200 pull = 1'b0;
        #200 scl = 1'b1;
        #200 b = sda;
        #200 scl = 1'b0;
    endtask
    // Works from idle and as a repeated start from a low clock
    task automatic start_c;
        #200 pull = 1'b0;
        #200 scl = 1'b1;
        #400 pull = 1'b1;
        #400 scl = 1'b0;
    endtask
    task automatic stop_c;
        #200 pull = 1'b1;
        #200 scl = 1'b1;
        #400 pull = 1'b0;
        #400 pull = 1'b0;
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = !b;
    endtask
    task automatic byte_r(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(!ack);
    endtask
endmodule
`default_nettype wire

// >>> dv/i2ce_slave_asserts.sv
// Protocol checker for the serial memory target engine
`timescale 1ns/100ps
`default_nettype none
module i2ce_slave_asserts #(
    parameter PAGE_BITS = 7,
    parameter TW_CYCLES = 200
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        scl,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic [2:0]  chip_select_straps,
    input wire logic        write_protect_input,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_we,
    input wire logic [7:0]  mem_rdata,
    input wire logic        busy,
    input wire logic [15:0] addr_count
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic [31:0] busy_cnt;
    logic        row_seen;
    logic [15:0] last_we;
    // Burst window closes only when both busy and strobe are low,
    // though busy rises in the same cycle as the commit strobe slot for page offset zero
    always @(posedge clk) begin
        if (rst || !busy) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= busy_cnt + 32'h1;
        end
        if (rst || (!busy && !mem_we)) begin
            row_seen <= 1'b0;
        end else if (mem_we) begin
            row_seen <= 1'b1;
        end
        if (mem_we) begin
            last_we <= mem_addr;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_clear;
        disable iff (1'b0) rst |=> (!busy && !sda_oe && !mem_we
            && addr_count == 16'h0000);
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not cleared by reset");
    property p_sda_low;
        sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data pin driven high");
    property p_busy_quiet;
        busy |-> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data pulled during write cycle");
    property p_we_in_cycle;
        mem_we |-> ##1 busy;
    endproperty
    a_we_in_cycle: assert property (p_we_in_cycle)
        else $error("array write outside write cycle");
    property p_busy_min;
        $rose(busy) |-> busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("write cycle too short");
    property p_busy_max;
        busy_cnt <= TW_CYCLES + 4;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("write cycle overran");
    property p_row_same;
        mem_we && row_seen |->
            mem_addr[15:PAGE_BITS] == last_we[15:PAGE_BITS];
    endproperty
    a_row_same: assert property (p_row_same)
        else $error("page write left its row");
    property p_offset_up;
        mem_we && row_seen |->
            mem_addr[PAGE_BITS-1:0] > last_we[PAGE_BITS-1:0];
    endproperty
    a_offset_up: assert property (p_offset_up)
        else $error("page offsets out of order");
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the serial memory target engine
`timescale 1ns/100ps
`default_nettype none
`include "i2ce_defines.vh"
module testbench;
    localparam int TW = 200;
    logic        clk, rst, sda_oe, sda_out, mem_we, busy, wp, scl, pull;
    logic        sda_line, ack;
    logic [2:0]  straps;
    logic [15:0] mem_addr, addr_count, cnt, a;
    logic [7:0]  mem_wdata, mem_rdata, d;
    logic [7:0]  mem [0:65535];
    logic [7:0]  exp_mem [0:65535];
    integer      seed, miscompares, checks, n;
    // ----------------------------------------------------------------
    // Clock, wire, array and instances
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #50 clk = ~clk;
    assign sda_line = !(sda_oe | pull);
    assign mem_rdata = mem[mem_addr];
    always @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
    i2ce_master_bfm m_u (.sda(sda_line), .scl(scl), .pull(pull));
    i2ce_slave #(.TW_CYCLES(TW)) dut_u (
        .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(straps),
        .write_protect_input(wp), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
        .busy(busy), .addr_count(addr_count));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] sel_b(input logic [2:0] s,
                                         input logic rw);
        return {`I2CE_DEV_TYPE, s, rw};
    endfunction
    function automatic logic [15:0] in_row(input logic [15:0] b,
                                           input integer k);
        return {b[15:7], b[6:0] + k[6:0]};
    endfunction
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic set_addr(input logic [15:0] x);
        m_u.start_c();
        m_u.byte_w(sel_b(straps, 1'b0), ack);
        chk("write select ack", 1, ack);
        m_u.byte_w(x[15:8], ack);
        chk("high address ack", 1, ack);
        m_u.byte_w(x[7:0], ack);
        chk("low address ack", 1, ack);
    endtask
    task automatic page_write(input logic [15:0] x, input integer k);
        set_addr(x);
        for (int i = 0; i < k; i++) begin
            d = $random(seed);
            m_u.byte_w(d, ack);
            chk("data ack", !wp, ack);
            if (!wp) exp_mem[in_row(x, i)] = d;
        end
        m_u.stop_c();
        chk("write cycle start", !wp, busy);
        m_u.start_c();
        m_u.byte_w(sel_b(straps, 1'b0), ack);
        chk("select while busy", wp, ack);
        m_u.stop_c();
        for (int i = 0; i < TW + 50 && busy !== 1'b0; i++) #100;
        chk("write cycle end", 0, busy);
        if (!wp) chk("counter after write", in_row(x, k), addr_count);
    endtask
    task automatic read_seq(input logic [15:0] x, input integer k,
                            input logic rnd);
        if (rnd) set_addr(x);
        m_u.start_c();
        m_u.byte_w(sel_b(straps, 1'b1), ack);
        chk("read select ack", 1, ack);
        for (int i = 0; i < k; i++) begin
            m_u.byte_r(i != k - 1, d);
            chk("read data", exp_mem[16'(x + i)], d);
        end
        m_u.stop_c();
        chk("counter after read", x + k, addr_count);
    endtask
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        #8000000;
        miscompares++;
        $display("[FAIL] run length expected finish seen timeout");
        end_sim();
    end
    initial begin
        seed = 32'h0a33ce2f;
        miscompares = 0;
        checks = 0;
        rst = 1'b1;
        wp = 1'b0;
        straps = $random(seed);
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
            exp_mem[i] = i[7:0] ^ 8'ha5;
        end
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        chk("counter at reset", 0, addr_count);
        for (int k = 0; k < 9; k++) begin
            m_u.start_c();
            m_u.byte_w(k < 8 ? sel_b(k[2:0], 1'b0) : ~sel_b(straps, 1'b1),
                       ack);
            chk("select match", k[2:0] == straps && k < 8, ack);
            m_u.stop_c();
        end
        set_addr(16'h1234);
        m_u.stop_c();
        chk("no cycle without data", 0, busy);
        page_write({7'h55, 9'h07e}, 5);
        read_seq(in_row({7'h55, 9'h07e}, 5), 2, 1'b0);
        read_seq({7'h55, 9'h000}, 4, 1'b1);
        repeat (3) begin
            a = $random(seed);
            n = 2 + {$random(seed)} % 20;
            page_write(a, n);
            read_seq(a, n, 1'b1);
        end
        @(posedge clk);
        #1 wp = 1'b1;
        page_write(a, 3);
        @(posedge clk);
        #1 wp = 1'b0;
        read_seq(a, 3, 1'b1);
        read_seq(16'hfffe, 3, 1'b1);
        end_sim();
    end
endmodule
bind i2ce_slave i2ce_slave_asserts #(.PAGE_BITS(PAGE_BITS),
    .TW_CYCLES(TW_CYCLES)) chk_u (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
    .write_protect_input(write_protect_input), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .busy(busy), .addr_count(addr_count));
`default_nettype wire

// >>> rtl/i2ce_defines.vh
// Shared constants of the serial memory target engine
`ifndef I2CE_DEFINES_VH
`define I2CE_DEFINES_VH

// --------------------------------------------------------------------
// Select byte layout
// --------------------------------------------------------------------
// Type code value is arbitrary, not that of any real part
`define I2CE_DEV_TYPE      4'h5
`define I2CE_TYPE_HI       7
`define I2CE_TYPE_LO       4
`define I2CE_STRAP_HI      3
`define I2CE_STRAP_LO      1
`define I2CE_RW_BIT        0
`define I2CE_RW_READ       1'b1

// --------------------------------------------------------------------
// Bit slot counting
// --------------------------------------------------------------------
`define I2CE_BIT_LAST      4'h7
`define I2CE_BIT_ACK       4'h8
`define I2CE_BIT_FIRST     4'h0
// A Stop in the tenth slot follows exactly one clock rise after the ack
`define I2CE_BIT_STOP      4'h1

// --------------------------------------------------------------------
// Sizes and timing
// --------------------------------------------------------------------
`define I2CE_ADDR_W        16
`define I2CE_BYTE_W        8
`define I2CE_PAGE_BITS     7
`define I2CE_CLK_PERIOD_NS 100
// Plain default for the internal write cycle time, in ns
`define I2CE_TW_NS         5000000
`define I2CE_TIMER_W       24

`endif

// >>> rtl/i2ce_line_sync.v
// Two-stage synchroniser and Start/Stop/edge detector for the bus lines
`timescale 1ns/100ps
`default_nettype none

module i2ce_line_sync (
    input  wire clk,
    input  wire rst,
    input  wire scl_pin,
    input  wire sda_pin,
    output reg  scl_s,
    output reg  sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);

    reg scl_m;
    reg sda_m;
    reg scl_d;
    reg sda_d;

    // --------------------------------------------------------------------
    // Synchronisers; first stage feeds only the second
    // --------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            scl_m <= 1'b1;
            sda_m <= 1'b1;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_pin;
            sda_m <= sda_pin;
            scl_s <= scl_m;
            sda_s <= sda_m;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // --------------------------------------------------------------------
    // Edge and condition decode
    // --------------------------------------------------------------------
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    // Clock held high across both samples, so a data edge is a condition
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

endmodule

`default_nettype wire

// >>> rtl/i2ce_page_buf.v
// Page latch: one byte and one valid flag per page offset
`timescale 1ns/100ps
`default_nettype none

module i2ce_page_buf #(
    parameter PAGE_BITS = 7
) (
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 clr,
    input  wire                 wr,
    input  wire [PAGE_BITS-1:0] wr_idx,
    input  wire [7:0]           wr_data,
    input  wire [PAGE_BITS-1:0] rd_idx,
    output wire [7:0]           rd_data,
    output wire                 rd_valid
);

    localparam DEPTH = 1 << PAGE_BITS;

    reg [7:0]       mem [0:DEPTH-1];
    reg [DEPTH-1:0] vld;

    // A wrapped write simply overwrites the earlier byte at that offset
    always @(posedge clk) begin
        if (rst || clr) begin
            vld <= {DEPTH{1'b0}};
        end else if (wr) begin
            vld[wr_idx] <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (wr) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data  = mem[rd_idx];
    assign rd_valid = vld[rd_idx];

endmodule

`default_nettype wire

// >>> rtl/i2ce_slave.v
// Target-side protocol engine of a two-wire byte-addressed memory
`timescale 1ns/100ps
`default_nettype none
`include "i2ce_defines.vh"

// What this block does
// - Detect Start: data falls while clock high
// - Ignore bus until Start, except during write
// - Stop, data rising with clock high, ends transfer
// - Stop after read no-ack gives standby
// - Transmitter releases after eight bits; receiver acks
// - Sample data on each rising clock edge
// - Select byte: type, strap address, direction, MSB first
// - Respond only when strap field matches straps
// - Eighth select bit: one reads, zero writes
// - Ack on match; mismatch releases, goes standby
// - Write accepts and acks two address bytes
// - Protect during addressing: no change, no data ack
// - Address is sixteen bits, high byte first
// - Write cycle only on Stop in tenth slot
// - After write, counter points past last byte
// - During write cycle: release data, ignore all
// - Byte write: ack if writable, else no ack
// - Page write up to one row per cycle
// - Page write increments only low page bits
// - Counter increments after each read byte
// - Sequential read wraps to location zero
// - Read no-ack stops data, enters standby
module i2ce_slave #(
    parameter PAGE_BITS = `I2CE_PAGE_BITS,
    parameter TIMER_W   = `I2CE_TIMER_W,
    parameter TW_CYCLES = `I2CE_TW_NS / `I2CE_CLK_PERIOD_NS
) (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    scl,
    input  wire                    sda_in,
    output reg                     sda_out,
    output reg                     sda_oe,
    input  wire [2:0]              chip_select_straps,
    input  wire                    write_protect_input,
    output reg  [`I2CE_ADDR_W-1:0] mem_addr,
    output reg  [`I2CE_BYTE_W-1:0] mem_wdata,
    output reg                     mem_we,
    input  wire [`I2CE_BYTE_W-1:0] mem_rdata,
    output reg                     busy,
    output reg  [`I2CE_ADDR_W-1:0] addr_count
);

    // --------------------------------------------------------------------
    // States
    // --------------------------------------------------------------------
    localparam S_IDLE = 8'h01;
    localparam S_DSEL = 8'h02;
    localparam S_AHI  = 8'h04;
    localparam S_ALO  = 8'h08;
    localparam S_WDAT = 8'h10;
    localparam S_RDAT = 8'h20;
    localparam S_RACK = 8'h40;
    localparam S_WCYC = 8'h80;

    localparam [TIMER_W-1:0] TW_LAST = TW_CYCLES - 1;

    reg [7:0]              state;
    reg [3:0]              bit_cnt;
    reg                    ack_phase;
    reg                    ack_ok;
    reg                    rw;
    reg                    wp_hold;
    reg                    have_data;
    reg [7:0]              shreg;
    reg [7:0]              tx;
    reg [`I2CE_ADDR_W-1:0] addr;
    reg [PAGE_BITS:0]      cidx;
    reg [TIMER_W-1:0]      timer;
    reg                    wp_m;
    reg                    wp_s;
    reg [2:0]              cs_m;
    reg [2:0]              cs_s;

    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire [7:0] buf_data;
    wire       buf_valid;

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function sel_match;
        input [7:0] b;
        input [2:0] straps;
        begin
            sel_match = (b[`I2CE_TYPE_HI:`I2CE_TYPE_LO] == `I2CE_DEV_TYPE)
                && (b[`I2CE_STRAP_HI:`I2CE_STRAP_LO] == straps);
        end
    endfunction

    function [`I2CE_ADDR_W-1:0] page_inc;
        input [`I2CE_ADDR_W-1:0] a;
        reg   [PAGE_BITS-1:0]    lo;
        begin
            lo       = a[PAGE_BITS-1:0] + 1'b1;
            page_inc = {a[`I2CE_ADDR_W-1:PAGE_BITS], lo};
        end
    endfunction

    wire       receiving = |(state & (S_DSEL | S_AHI | S_ALO | S_WDAT));
    wire [7:0] rx_byte   = {shreg[6:0], sda_s};
    wire       rx_done   = scl_rise && receiving && !ack_phase
                           && (bit_cnt == `I2CE_BIT_LAST);
    wire       buf_wr    = rx_done && (state == S_WDAT) && !wp_hold;
    wire       buf_clr   = rx_done && (state == S_ALO);
    // Stop needs the clock high, so its rise is already counted here
    wire       slot10    = (state == S_WDAT) && !ack_phase
                           && (bit_cnt == `I2CE_BIT_STOP);

    // --------------------------------------------------------------------
    // Line and pin synchronisers
    // --------------------------------------------------------------------
    i2ce_line_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .scl_pin   (scl),
        .sda_pin   (sda_in),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    always @(posedge clk) begin
        if (rst) begin
            wp_m <= 1'b0;
            wp_s <= 1'b0;
            cs_m <= 3'h0;
            cs_s <= 3'h0;
        end else begin
            wp_m <= write_protect_input;
            wp_s <= wp_m;
            cs_m <= chip_select_straps;
            cs_s <= cs_m;
        end
    end

    // --------------------------------------------------------------------
    // Page latch, drained during the write cycle
    // --------------------------------------------------------------------
    i2ce_page_buf #(
        .PAGE_BITS (PAGE_BITS)
    ) u_page (
        .clk      (clk),
        .rst      (rst),
        .clr      (buf_clr),
        .wr       (buf_wr),
        .wr_idx   (addr[PAGE_BITS-1:0]),
        .wr_data  (rx_byte),
        .rd_idx   (cidx[PAGE_BITS-1:0]),
        .rd_data  (buf_data),
        .rd_valid (buf_valid)
    );

    // --------------------------------------------------------------------
    // Protocol engine
    // --------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            state     <= S_IDLE;
            bit_cnt   <= `I2CE_BIT_FIRST;
            ack_phase <= 1'b0;
            ack_ok    <= 1'b0;
            rw        <= 1'b0;
            wp_hold   <= 1'b0;
            have_data <= 1'b0;
            shreg     <= 8'h00;
            tx        <= 8'hff;
            addr      <= 16'h0000;
            cidx      <= {(PAGE_BITS+1){1'b0}};
            timer     <= {TIMER_W{1'b0}};
            sda_oe    <= 1'b0;
        end else if (state == S_WCYC) begin
            // Bus is ignored entirely while the array is written
            sda_oe <= 1'b0;
            timer  <= timer + 1'b1;
            if (!cidx[PAGE_BITS]) begin
                cidx <= cidx + 1'b1;
            end
            if (timer == TW_LAST) begin
                // Counter already sits past the last byte taken in
                state <= S_IDLE;
            end
        end else if (start_det) begin
            // Repeated Start keeps the counter for a random read
            state     <= S_DSEL;
            bit_cnt   <= `I2CE_BIT_FIRST;
            ack_phase <= 1'b0;
            sda_oe    <= 1'b0;
            wp_hold   <= wp_s;
            have_data <= 1'b0;
        end else if (stop_det) begin
            sda_oe    <= 1'b0;
            ack_phase <= 1'b0;
            bit_cnt   <= `I2CE_BIT_FIRST;
            if (slot10 && have_data && !wp_hold) begin
                state <= S_WCYC;
                cidx  <= {(PAGE_BITS+1){1'b0}};
                timer <= {TIMER_W{1'b0}};
            end else begin
                state <= S_IDLE;
            end
        end else if (receiving) begin
            if (state != S_WDAT) begin
                wp_hold <= wp_hold | wp_s;
            end
            if (scl_rise && !ack_phase) begin
                shreg   <= rx_byte;
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (rx_done) begin
                case (state)
                    S_DSEL: begin
                        ack_ok <= 1'b1;
                        rw     <= rx_byte[`I2CE_RW_BIT];
                        if (!sel_match(rx_byte, cs_s)) begin
                            state <= S_IDLE;
                        end
                    end
                    S_AHI: begin
                        addr[15:8] <= rx_byte;
                        ack_ok     <= 1'b1;
                    end
                    S_ALO: begin
                        addr[7:0] <= rx_byte;
                        ack_ok    <= 1'b1;
                    end
                    S_WDAT: begin
                        ack_ok <= !wp_hold;
                        if (!wp_hold) begin
                            addr      <= page_inc(addr);
                            have_data <= 1'b1;
                        end
                    end
                    default: begin
                        ack_ok <= 1'b0;
                    end
                endcase
            end
            if (scl_fall && !ack_phase && (bit_cnt == `I2CE_BIT_ACK)) begin
                ack_phase <= 1'b1;
                sda_oe    <= ack_ok;
            end
            if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                bit_cnt   <= `I2CE_BIT_FIRST;
                sda_oe    <= 1'b0;
                case (state)
                    S_DSEL: begin
                        if (rw == `I2CE_RW_READ) begin
                            state  <= S_RDAT;
                            tx     <= mem_rdata;
                            sda_oe <= !mem_rdata[7];
                        end else begin
                            state <= S_AHI;
                        end
                    end
                    S_AHI: begin
                        state <= S_ALO;
                    end
                    S_ALO: begin
                        state <= S_WDAT;
                    end
                    default: begin
                        state <= S_WDAT;
                    end
                endcase
            end
        end else if (state == S_RDAT) begin
            if (scl_rise) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (scl_fall) begin
                if (bit_cnt == `I2CE_BIT_ACK) begin
                    sda_oe <= 1'b0;
                    state  <= S_RACK;
                end else begin
                    tx     <= {tx[6:0], 1'b1};
                    sda_oe <= !tx[6];
                end
            end
        end else if (state == S_RACK) begin
            if (scl_rise) begin
                addr <= addr + 1'b1;
                if (sda_s) begin
                    state <= S_IDLE;
                end else begin
                    ack_phase <= 1'b1;
                end
            end
            if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                bit_cnt   <= `I2CE_BIT_FIRST;
                state     <= S_RDAT;
                tx        <= mem_rdata;
                sda_oe    <= !mem_rdata[7];
            end
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // Memory port and status outputs
    // --------------------------------------------------------------------
    // Read address lags the counter one cycle; the bus leaves ample time
    always @(posedge clk) begin
        if (rst) begin
            mem_addr   <= 16'h0000;
            mem_wdata  <= 8'h00;
            mem_we     <= 1'b0;
            busy       <= 1'b0;
            addr_count <= 16'h0000;
            sda_out    <= 1'b0;
        end else begin
            sda_out    <= 1'b0;
            addr_count <= addr;
            busy       <= (state == S_WCYC);
            mem_we     <= 1'b0;
            mem_addr   <= addr;
            mem_wdata  <= buf_data;
            if ((state == S_WCYC) && !cidx[PAGE_BITS]) begin
                mem_addr <= {addr[`I2CE_ADDR_W-1:PAGE_BITS],
                             cidx[PAGE_BITS-1:0]};
                mem_we   <= buf_valid;
            end
        end
    end

endmodule

`default_nettype wire
